// File: design/dl_seq_pkg.sv
// Constants, register map and state type for the downlink sequencer
package dl_seq_pkg;
  // Register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  // Register byte offsets
  localparam logic [7:0] CODEC_CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] OFFSET_I_OFS = 8'h08;
  localparam logic [7:0] OFFSET_Q_OFS = 8'h0C;
  // Field positions
  localparam int EXT_CAL_BIT = 9;
  localparam int ST_POWERED_BIT = 0;
  localparam int ST_SETTLING_BIT = 1;
  localparam int ST_CAL_BIT = 2;
  localparam int ST_CONV_BIT = 3;
  localparam int ST_UPLINK_BIT = 4;
  localparam int ST_OVERRUN_BIT = 5;
  // Reset values
  localparam logic [15:0] CODEC_CTRL_RST = 16'h0000;
  localparam logic [11:0] OFFSET_RST = 12'h000;
  // Window indices inside the synchroniser vector
  localparam int WIN_PWR = 0;
  localparam int WIN_CAL = 1;
  localparam int WIN_CONV = 2;
  localparam int WIN_N = 3;
  // Datapath
  localparam int MOD_W = 2;
  localparam int SAMPLE_W = 12;
  localparam logic [4:0] DECIM_RATIO = 5'h18;
  localparam logic [3:0] DISCARD_SAMPLES = 4'h8;
  localparam int FIFO_DEPTH = 8;
  // Timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SETTLE_TIME_NS = 10000;
  localparam int SETTLE_CYCLES = (SETTLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SETTLE_W = 12;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_OFF, ST_SETTLE, ST_ON, ST_CAL, ST_CONV, ST_DRAIN
  } seq_state_t;
endpackage

// File: design/stream_if.sv
// Valid/ready stream carrier between the sequencer and its sample buffer
`timescale 1ns/1ps
interface stream_if #(parameter int W = 24);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport tx (output valid, output data, input ready);
  modport rx (input valid, input data, output ready);
endinterface

// File: design/sample_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sample_fifo #(
  parameter int W = 24,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  stream_if.rx in_s,
  stream_if.tx out_s
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  // Handshakes; full and empty follow the occupancy count
  assign in_s.ready = (count_q != (AW+1)'(DEPTH));
  assign out_s.valid = (count_q != '0);
  assign out_s.data = mem_q[rd_ptr_q];
  assign push = in_s.valid & in_s.ready;
  assign pop = out_s.valid & out_s.ready;

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_s.data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// File: design/downlink_sequencer.sv
// Baseband downlink receive sequencer: windows, decimation, offset and output
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module downlink_sequencer (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic downlink_power_window,
  input wire logic downlink_cal_window,
  input wire logic downlink_convert_window,
  input wire logic mod_strobe,
  input wire logic [dl_seq_pkg::MOD_W-1:0] mod_i,
  input wire logic [dl_seq_pkg::MOD_W-1:0] mod_q,
  input wire logic [dl_seq_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [dl_seq_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [dl_seq_pkg::DATA_W-1:0] reg_rdata,
  output logic sample_valid,
  input wire logic sample_ready,
  output logic [dl_seq_pkg::SAMPLE_W-1:0] sample_i,
  output logic [dl_seq_pkg::SAMPLE_W-1:0] sample_q,
  output logic analog_power_en,
  output logic path_powered,
  output logic inputs_shorted,
  output logic tx_to_uplink
);
  import dl_seq_pkg::*;

  // Local reset, released two edges after the pin
  logic rst_s1_q;
  logic rst_n;

  // Window synchronisers and edge pulses
  logic [WIN_N-1:0] win_s1_q;
  logic [WIN_N-1:0] win_s2_q;
  logic [WIN_N-1:0] win_prev_q;
  logic [WIN_N-1:0] win_rise;
  logic [WIN_N-1:0] win_fall;

  // Sequencer state and analog settling count
  seq_state_t state_q;
  logic [SETTLE_W-1:0] settle_q;

  // Decimation and delivery control
  logic restart;
  logic run;
  logic delivering;
  logic [4:0] phase_q;
  logic last_phase;
  logic dec_valid_q;
  logic [3:0] discard_q;
  logic push;

  // Software visible control and status
  logic [15:0] ctrl_q;
  logic ext_cal;
  logic overrun_q;
  logic [DATA_W-1:0] rd_mux;

  // Per-channel datapath, index 0 is I and 1 is Q
  logic [MOD_W-1:0] ch_in [2];
  logic [SAMPLE_W-1:0] acc_q [2];
  logic [SAMPLE_W-1:0] dec_q [2];
  logic [SAMPLE_W-1:0] off_q [2];
  logic [SAMPLE_W-1:0] corr [2];

  // Stream carriers into and out of the sample buffer
  stream_if #(.W(2 * SAMPLE_W)) fill_s ();
  stream_if #(.W(2 * SAMPLE_W)) drain_s ();

  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // Window synchronisers; only the second stage and its delayed copy are looked at
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      win_s1_q <= '0;
      win_s2_q <= '0;
      win_prev_q <= '0;
    end else begin
      win_s1_q <= {downlink_convert_window, downlink_cal_window,
                   downlink_power_window};
      win_s2_q <= win_s1_q;
      win_prev_q <= win_s2_q;
    end
  end

  // Edge detection on the synchronised windows
  assign win_rise = win_s2_q & ~win_prev_q;
  assign win_fall = ~win_s2_q & win_prev_q;

  // Window sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_OFF;
    end else begin
      case (state_q)
        ST_OFF: begin
          if (win_s2_q[WIN_PWR]) begin
            state_q <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (!win_s2_q[WIN_PWR]) begin
            state_q <= ST_OFF;
          end else if (settle_q == SETTLE_W'(SETTLE_CYCLES - 1)) begin
            state_q <= ST_ON;
          end
        end
        ST_ON: begin
          if (!win_s2_q[WIN_PWR]) begin
            state_q <= ST_OFF;
          end else if (win_s2_q[WIN_CAL]) begin
            state_q <= ST_CAL;
          end else if (win_rise[WIN_CONV]) begin
            state_q <= ST_CONV;
          end
        end
        ST_CAL: begin
          if (!win_s2_q[WIN_PWR]) begin
            state_q <= ST_OFF;
          end else if (!win_s2_q[WIN_CAL]) begin
            state_q <= ST_ON;
          end
        end
        ST_CONV: begin
          if (!win_s2_q[WIN_PWR]) begin
            state_q <= ST_OFF;
          end else if (win_fall[WIN_CONV]) begin
            state_q <= ST_DRAIN;
          end
        end
        ST_DRAIN: begin
          if (!win_s2_q[WIN_PWR]) begin
            state_q <= ST_OFF;
          end else if (dec_valid_q) begin
            state_q <= ST_ON;
          end
        end
        default: begin
          state_q <= ST_OFF;
        end
      endcase
    end
  end

  // Analog settling counter, cleared whenever the path is not settling
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_q <= '0;
    end else if (state_q == ST_SETTLE) begin
      settle_q <= settle_q + 1'b1;
    end else begin
      settle_q <= '0;
    end
  end

  // Filter run control: a fresh decimation frame on each window start
  assign restart = (state_q == ST_ON) &&
                   (win_s2_q[WIN_CAL] || win_rise[WIN_CONV]);
  assign run = (state_q == ST_CAL) || (state_q == ST_CONV) || (state_q == ST_DRAIN);
  assign delivering = (state_q == ST_CONV) || (state_q == ST_DRAIN);
  assign last_phase = (phase_q == DECIM_RATIO - 5'h01);

  // Decimation phase shared by both channels
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= '0;
      dec_valid_q <= 1'b0;
    end else begin
      dec_valid_q <= run && mod_strobe && last_phase;
      if (restart || !run) begin
        phase_q <= '0;
      end else if (mod_strobe) begin
        phase_q <= last_phase ? 5'h00 : phase_q + 5'h01;
      end
    end
  end

  // Modulator words feed the channels, I first
  assign ch_in[0] = mod_i;
  assign ch_in[1] = mod_q;

  // Two identical channels: boxcar decimator, offset store, correction
  for (genvar c = 0; c < 2; c++) begin : g_chan
    logic [SAMPLE_W-1:0] word;

    // Two-bit modulator word as a signed value
    assign word = {{(SAMPLE_W - MOD_W){ch_in[c][MOD_W-1]}}, ch_in[c]};

    // Accumulate 24 words, then hand the sum over as one sample
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        acc_q[c] <= '0;
        dec_q[c] <= '0;
      end else if (restart || !run) begin
        acc_q[c] <= '0;
      end else if (mod_strobe) begin
        if (last_phase) begin
          acc_q[c] <= '0;
          dec_q[c] <= acc_q[c] + word;
        end else begin
          acc_q[c] <= acc_q[c] + word;
        end
      end
    end

    // Offset store, loaded only by calibration results
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        off_q[c] <= OFFSET_RST;
      end else if (state_q == ST_CAL && dec_valid_q) begin
        off_q[c] <= dec_q[c];
      end
    end

    // Offset-corrected sample
    assign corr[c] = dec_q[c] - off_q[c];
  end

  // Drop the samples spoilt by filter group delay
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      discard_q <= '0;
    end else if (restart) begin
      discard_q <= '0;
    end else if (delivering && dec_valid_q && discard_q != DISCARD_SAMPLES) begin
      discard_q <= discard_q + 4'h1;
    end
  end

  assign push = delivering && dec_valid_q && (discard_q == DISCARD_SAMPLES);

  // Samples into the output buffer
  assign fill_s.valid = push;
  assign fill_s.data = {corr[0], corr[1]};

  sample_fifo #(.W(2 * SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_s(fill_s),
    .out_s(drain_s)
  );

  // Serial port side of the buffer
  assign sample_valid = drain_s.valid;
  assign drain_s.ready = sample_ready;
  assign sample_i = drain_s.data[2*SAMPLE_W-1:SAMPLE_W];
  assign sample_q = drain_s.data[SAMPLE_W-1:0];

  // Codec control register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CODEC_CTRL_RST;
    end else if (reg_we && reg_addr == CODEC_CTRL_OFS) begin
      ctrl_q <= reg_wdata;
    end
  end

  // Calibration mode only steers the input short switch
  assign ext_cal = ctrl_q[EXT_CAL_BIT];

  // Overrun flag: a sample met a full buffer; a new loss beats the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_q <= 1'b0;
    end else if (push && !fill_s.ready) begin
      overrun_q <= 1'b1;
    end else if (reg_we && reg_addr == STATUS_OFS && reg_wdata[ST_OVERRUN_BIT]) begin
      overrun_q <= 1'b0;
    end
  end

  // Read decode; unmapped addresses read zero
  always_comb begin
    rd_mux = '0;
    case (reg_addr)
      CODEC_CTRL_OFS: rd_mux = ctrl_q;
      STATUS_OFS: begin
        rd_mux[ST_POWERED_BIT] = path_powered;
        rd_mux[ST_SETTLING_BIT] = (state_q == ST_SETTLE);
        rd_mux[ST_CAL_BIT] = (state_q == ST_CAL);
        rd_mux[ST_CONV_BIT] = delivering;
        rd_mux[ST_UPLINK_BIT] = tx_to_uplink;
        rd_mux[ST_OVERRUN_BIT] = overrun_q;
      end
      OFFSET_I_OFS: rd_mux = {{(DATA_W - SAMPLE_W){off_q[0][SAMPLE_W-1]}}, off_q[0]};
      OFFSET_Q_OFS: rd_mux = {{(DATA_W - SAMPLE_W){off_q[1][SAMPLE_W-1]}}, off_q[1]};
      default: rd_mux = '0;
    endcase
  end

  // Read data stands for the one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_re) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= '0;
    end
  end

  // Analog control outputs, registered from the sequencer state and the calibration mode bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      analog_power_en <= 1'b0;
      path_powered <= 1'b0;
      inputs_shorted <= 1'b0;
      tx_to_uplink <= 1'b0;
    end else begin
      analog_power_en <= (state_q != ST_OFF);
      path_powered <= run || (state_q == ST_ON);
      inputs_shorted <= (state_q == ST_CAL) && !ext_cal;
      tx_to_uplink <= delivering;
    end
  end
endmodule

// File: verif/dl_seq_checker.sv
// Port assertions for the downlink sequencer
`timescale 1ns/1ps
module dl_seq_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic mod_strobe,
  input wire logic downlink_power_window,
  input wire logic downlink_convert_window,
  input wire logic [dl_seq_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [dl_seq_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [dl_seq_pkg::DATA_W-1:0] reg_rdata,
  input wire logic sample_valid,
  input wire logic sample_ready,
  input wire logic [dl_seq_pkg::SAMPLE_W-1:0] sample_i,
  input wire logic [dl_seq_pkg::SAMPLE_W-1:0] sample_q,
  input wire logic analog_power_en,
  input wire logic path_powered,
  input wire logic inputs_shorted,
  input wire logic tx_to_uplink
);
  import dl_seq_pkg::*;
  logic ext_q;
  logic [11:0] wait_q;
  logic [11:0] strobe_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Calibration mode bit as software wrote it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_q <= 1'b0;
    end else if (reg_we && reg_addr == CODEC_CTRL_OFS) begin
      ext_q <= reg_wdata[EXT_CAL_BIT];
    end
  end
  // Settling cycles between power enable and power-on mode
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_q <= 12'h000;
    end else if (!analog_power_en) begin
      wait_q <= 12'h000;
    end else if (!path_powered) begin
      wait_q <= wait_q + 12'h001;
    end
  end
  // Modulator words seen since the uplink routing came on
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strobe_q <= 12'h000;
    end else if (!tx_to_uplink) begin
      strobe_q <= 12'h000;
    end else if (mod_strobe) begin
      strobe_q <= strobe_q + 12'h001;
    end
  end
  settle_time_a: assert property ($rose(path_powered) |->
    wait_q >= 12'(SETTLE_CYCLES - 2) && wait_q <= 12'(SETTLE_CYCLES + 4))
    else $error("power-on mode after wrong delay");
  power_order_a: assert property (path_powered |-> analog_power_en)
    else $error("powered without analog enable");
  power_down_a: assert property (!downlink_power_window [*6] |->
    !analog_power_en && !path_powered)
    else $error("still powered after power window fell");
  short_mode_a: assert property (inputs_shorted |-> !ext_q && !tx_to_uplink)
    else $error("inputs shorted in wrong mode");
  uplink_route_a: assert property ($rose(tx_to_uplink) |-> downlink_convert_window)
    else $error("uplink routing without convert window");
  first_drop_a: assert property ($rose(tx_to_uplink) && !sample_valid |=>
    !sample_valid [*8])
    else $error("sample delivered too early");
  discard_count_a: assert property ($rose(sample_valid) && tx_to_uplink |->
    strobe_q >= 12'((int'(DISCARD_SAMPLES) + 1) * int'(DECIM_RATIO) - 1))
    else $error("sample delivered before the discarded ones");
  drain_stop_a: assert property ($fell(tx_to_uplink) |-> !downlink_convert_window)
    else $error("conversion stopped inside window");
  rdata_idle_a: assert property (!$past(reg_re) |-> reg_rdata == 16'h0000)
    else $error("read data outside read slot");
  hold_sample_a: assert property (sample_valid && !sample_ready |=>
    sample_valid && $stable(sample_i) && $stable(sample_q))
    else $error("stalled sample changed");
endmodule
bind downlink_sequencer dl_seq_checker u_chk (.clk(clk), .arst_n(arst_n), .mod_strobe(mod_strobe),
  .downlink_power_window(downlink_power_window),
  .downlink_convert_window(downlink_convert_window), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
  .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_i(sample_i),
  .sample_q(sample_q), .analog_power_en(analog_power_en), .path_powered(path_powered),
  .inputs_shorted(inputs_shorted), .tx_to_uplink(tx_to_uplink));

// File: verif/host_tpu_model.sv
// Host timing unit and sample consumer model
`timescale 1ns/1ps
module host_tpu_model (
  input wire logic clk,
  input wire logic [1:0] phase,
  input wire logic [1:0] ready_mode,
  input wire logic sample_valid,
  input wire logic [11:0] sample_i,
  input wire logic [11:0] sample_q,
  output logic downlink_power_window,
  output logic downlink_cal_window,
  output logic downlink_convert_window,
  output logic sample_ready,
  output logic [15:0] rx_count,
  output logic [11:0] last_i,
  output logic [11:0] last_q
);
  logic tog_q;
  // Quiet start
  initial begin
    {downlink_power_window, downlink_cal_window, downlink_convert_window} = 3'h0;
    {sample_ready, tog_q, rx_count, last_i, last_q} = '0;
  end
  // Windows nest inside power: calibrate and convert never overlap
  always @(posedge clk) begin
    downlink_power_window <= (phase != 2'h0);
    downlink_cal_window <= (phase == 2'h2);
    downlink_convert_window <= (phase == 2'h3);
  end
  // Consumer pace: always, every other cycle, or stalled
  always @(posedge clk) begin
    tog_q <= ~tog_q;
    sample_ready <= (ready_mode == 2'h0) || (ready_mode == 2'h1 && tog_q);
  end
  // Collect popped samples
  always @(posedge clk) begin
    if (sample_valid && sample_ready) begin
      rx_count <= rx_count + 16'h0001;
      last_i <= sample_i;
      last_q <= sample_q;
    end
  end
endmodule

// File: verif/testbench.sv
// Self-checking testbench for the downlink sequencer
`timescale 1ns/1ps
module testbench;
  import dl_seq_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic downlink_power_window, downlink_cal_window, downlink_convert_window;
  logic mod_strobe, reg_we, reg_re, feed, sample_valid, sample_ready;
  logic analog_power_en, path_powered, inputs_shorted, tx_to_uplink;
  logic [1:0] mod_i, mod_q, phase, ready_mode;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rx_count, rd;
  logic [11:0] sample_i, sample_q, last_i, last_q;
  int err_count = 0;
  int checks_done = 0;
  always #2.5 clk = ~clk;
  // Modulator strobe every other cycle while feeding
  always @(posedge clk) mod_strobe <= feed && !mod_strobe;
  downlink_sequencer u_dut (.clk(clk), .arst_n(arst_n),
    .downlink_power_window(downlink_power_window), .downlink_cal_window(downlink_cal_window),
    .downlink_convert_window(downlink_convert_window), .mod_strobe(mod_strobe),
    .mod_i(mod_i), .mod_q(mod_q), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .sample_i(sample_i), .sample_q(sample_q),
    .analog_power_en(analog_power_en), .path_powered(path_powered),
    .inputs_shorted(inputs_shorted), .tx_to_uplink(tx_to_uplink));
  host_tpu_model u_host (.clk(clk), .phase(phase), .ready_mode(ready_mode),
    .sample_valid(sample_valid), .sample_i(sample_i), .sample_q(sample_q),
    .downlink_power_window(downlink_power_window), .downlink_cal_window(downlink_cal_window),
    .downlink_convert_window(downlink_convert_window), .sample_ready(sample_ready),
    .rx_count(rx_count), .last_i(last_i), .last_q(last_q));
  // Comparison, register access and waiting helpers
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input string msg);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    // Read data stand until the next edge and are taken there before they clear
    @(posedge clk);
    rd = reg_rdata;
    check(rd, exp, msg);
  endtask
  // Reset values, unmapped read, software write to a calibrated register
  task automatic t_regs();
    rd_chk(OFFSET_I_OFS, 16'h0000, "offset I reset");
    rd_chk(OFFSET_Q_OFS, 16'h0000, "offset Q reset");
    rd_chk(CODEC_CTRL_OFS, CODEC_CTRL_RST, "control reset");
    rd_chk(8'h10, 16'h0000, "unmapped read");
    reg_wr(OFFSET_I_OFS, 16'h0123);
    rd_chk(OFFSET_I_OFS, 16'h0000, "offset after write");
    $display("test registers done");
  endtask
  // Power-up waits for the settling delay
  task automatic t_power();
    int n;
    n = 0;
    phase <= 2'h1;
    while (path_powered !== 1'b1 && n < SETTLE_CYCLES + 100) begin
      @(posedge clk);
      n++;
    end
    check(16'(n > SETTLE_CYCLES - 1 && n < SETTLE_CYCLES + 12), 16'h0001, "settling");
    $display("test power done");
  endtask
  // Calibration in one mode stores the decimated conversion
  task automatic t_cal(input logic ext, input logic [1:0] mi, input logic [1:0] mq,
                       input logic [15:0] ei, input logic [15:0] eq);
    reg_wr(CODEC_CTRL_OFS, {6'h00, ext, 9'h000});
    mod_i <= mi;
    mod_q <= mq;
    feed <= 1'b1;
    phase <= 2'h2;
    step(300);
    check(16'(inputs_shorted), 16'(!ext), "input shorting");
    phase <= 2'h1;
    step(20);
    rd_chk(OFFSET_I_OFS, ei, "offset I");
    rd_chk(OFFSET_Q_OFS, eq, "offset Q");
    $display("test calibration done");
  endtask
  // Burst conversion with a slow consumer and a window closing mid-sample
  task automatic t_conv(input logic [1:0] mode, input int len, input logic [15:0] cnt);
    logic [15:0] base;
    base = rx_count;
    mod_i <= 2'h0;
    mod_q <= 2'h0;
    ready_mode <= mode;
    phase <= 2'h3;
    step(40);
    check(16'(tx_to_uplink), 16'h0001, "uplink routing");
    step(len);
    phase <= 2'h1;
    step(100);
    check(16'(tx_to_uplink), 16'h0000, "routing after drain");
    if (mode == 2'h2) begin
      rd_chk(STATUS_OFS, 16'(1 << ST_OVERRUN_BIT | 1 << ST_POWERED_BIT), "overrun");
      reg_wr(STATUS_OFS, 16'h0020);
      rd_chk(STATUS_OFS, 16'(1 << ST_POWERED_BIT), "overrun cleared");
      ready_mode <= 2'h0;
      step(30);
      check(16'(sample_valid), 16'h0000, "buffer drained");
    end
    check(rx_count - base, cnt, "sample count");
    check({4'h0, last_i}, 16'h0FE8, "corrected I");
    check({4'h0, last_q}, 16'h0018, "corrected Q");
    $display("test conversion done");
  endtask
  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Main sequence: power, calibrate, convert, overrun, power down
  initial begin
    {reg_we, reg_re, feed, mod_strobe, mod_i, mod_q, phase, ready_mode} = '0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    step(2);
    arst_n <= 1'b1;
    step(4);
    t_regs();
    t_power();
    t_cal(1'b1, 2'h2, 2'h0, 16'hFFD0, 16'h0000);
    t_cal(1'b0, 2'h1, 2'h3, 16'h0018, 16'hFFE8);
    t_conv(2'h1, 560, 16'h0005);
    t_conv(2'h2, 960, 16'h0008);
    phase <= 2'h0;
    step(8);
    check(16'(analog_power_en), 16'h0000, "power down");
    end_sim();
  end
endmodule
